// *** design/link_hdlc_tx_pkg.sv ***
package link_hdlc_tx_pkg;

   // ----------------------------------------------------------------
   // register indices and byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CFG_IDX  = 8'h34;
   localparam logic [7:0] REG_STAT_IDX = 8'h35;
   localparam logic [7:0] REG_DATA_IDX = 8'h36;
   localparam logic [7:0] REG_OPT_IDX  = 8'h37;
   localparam logic [7:0] ADDR_CFG     = 8'(REG_CFG_IDX * 4);
   localparam logic [7:0] ADDR_STAT    = 8'(REG_STAT_IDX * 4);
   localparam logic [7:0] ADDR_DATA    = 8'(REG_DATA_IDX * 4);
   localparam logic [7:0] ADDR_OPT     = 8'(REG_OPT_IDX * 4);

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CFG_EN      = 0;
   localparam int CFG_CRC     = 1;
   localparam int CFG_ABT     = 2;
   localparam int CFG_IRQ_OUTPUT_ENABLE    = 3;
   localparam int CFG_EOM     = 4;
   localparam int STAT_UDR    = 0;
   localparam int STAT_BYTREQ = 1;
   localparam int OPT_ROUTE   = 0;

   // ----------------------------------------------------------------
   // line patterns, lengths and check sequence
   // ----------------------------------------------------------------
   localparam logic [7:0]  PAT_FLAG    = 8'h7e;
   localparam logic [7:0]  PAT_ABORT   = 8'h7f;
   localparam logic [7:0]  PAT_ONES    = 8'hff;
   localparam logic [4:0]  BYTE_BITS   = 5'h08;
   localparam logic [4:0]  FCS_BITS    = 5'h10;
   localparam logic [4:0]  LAST_BIT    = 5'h01;
   localparam logic [2:0]  STUFF_RUN   = 3'h5;
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'h1021;

   typedef enum logic [6:0] {
      TX_IDLE  = 7'b0000001,
      TX_FLAG  = 7'b0000010,
      TX_DATA  = 7'b0000100,
      TX_FCS   = 7'b0001000,
      TX_ABORT = 7'b0010000,
      TX_UFLAG = 7'b0100000,
      TX_ONES  = 7'b1000000
   } txstate_t;

endpackage

// *** design/fcs16_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
module fcs16_gen
   import link_hdlc_tx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        init,
   input  wire logic        shiftEn,
   input  wire logic        dataBit,
   output logic [15:0]      crcNext
);

   typedef struct packed {
      logic [15:0] crc;
   } fcs_t;

   fcs_t s_r;
   fcs_t s_nxt;

   // ----------------------------------------------------------------
   // serial divider, one data bit per shift
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] c;
      logic        fb;
      c  = init ? CRC_INIT : s_r.crc;
      fb = c[15] ^ dataBit;
      if (shiftEn) begin
         c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      crcNext   = c;
      s_nxt.crc = c;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '{crc: CRC_INIT};
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

endmodule
`default_nettype wire

// *** design/link_zero_stuffer.sv ***
`timescale 1ns/100ps
`default_nettype none
module link_zero_stuffer
   import link_hdlc_tx_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   input  wire logic clr,
   input  wire logic adv,
   input  wire logic countEn,
   input  wire logic sentBit,
   output logic      insertZero
);

   typedef struct packed {
      logic [2:0] run;
   } stuff_t;

   stuff_t s_r;
   stuff_t s_nxt;

   // ----------------------------------------------------------------
   // run of ones since the last zero on the line
   // ----------------------------------------------------------------
   // flags and aborts reset the run, so only data and check bits can trigger a zero
   assign insertZero = (s_r.run == STUFF_RUN);

   always_comb begin
      s_nxt = s_r;
      if (clr) begin
         s_nxt.run = '0;
      end else if (adv) begin
         if (insertZero || !countEn || !sentBit) begin
            s_nxt.run = '0;
         end else begin
            s_nxt.run = s_r.run + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '{run: '0};
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

endmodule
`default_nettype wire

// *** design/link_hdlc_tx.sv ***
// Summary of operation
// - enable sends flags until data, else disabled
// - check enable appends 16-bit check word
// - CCITT polynomial, high order check bit first
// - abort request repeats 11111110 until cleared
// - interrupt enable gates link interrupt output
// - routing option mirrors interrupt onto host pin
// - end mark: check word, then continuous flags
// - end mark self-clears before next packet
// - byte request set on shifter load, cleared by data
// - byte request independent of interrupt enable
// - byte request reads one after reset
// - underrun set when shifter empties without data
// - after underrun send abort, one flag, wait
// - underrun still set: send all-ones idle
// - underrun cleared only by writing zero
// - data bytes sent least significant bit first
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module link_hdlc_tx
   import link_hdlc_tx_pkg::*;
#(
   // byte address width of the register bus
   parameter int ADDR_W = 8
)(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              bitStrobe,
   output logic                   txBit,
   output logic                   linkIrqOut,
   output logic                   hostIrqN
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      txstate_t    st;
      logic [15:0] sh;
      logic [4:0]  cnt;
      // configuration and status
      logic        en;
      logic        crcEn;
      logic        abort_request;
      logic        irq_output_enable;
      logic        end_of_message_mark;
      logic        route;
      logic        underrun_flag;
      logic        held;
      logic [7:0]  dat;
      // registered outputs
      logic        txBit;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        linkIrq;
      logic        hostIrqN;
   } main_t;

   localparam main_t RESET_STATE = '{
      st:       TX_IDLE,
      sh:       16'h0000,
      cnt:      5'h00,
      en:       1'b0,
      crcEn:    1'b0,
      abort_request:      1'b0,
      irq_output_enable:     1'b0,
      end_of_message_mark:      1'b0,
      route:    1'b0,
      underrun_flag:      1'b0,
      // nothing held, so the byte request reads one
      held:     1'b0,
      dat:      8'h00,
      txBit:    1'b1,
      prdata:   32'h0000_0000,
      pready:   1'b0,
      pslverr:  1'b0,
      linkIrq:  1'b0,
      hostIrqN: 1'b1
   };

   main_t s_r;
   main_t s_nxt;

   logic        stuffNow;
   logic [15:0] crcNext;
   logic        bitTick;
   logic        payloadBit;
   logic        crcInit;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // anything else answers with a slave error and reads zero
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_W'(ADDR_CFG)) || (a == ADDR_W'(ADDR_STAT)) ||
             (a == ADDR_W'(ADDR_DATA)) || (a == ADDR_W'(ADDR_OPT));
   endfunction

   // the byte request reaches a pin only while its interrupt is enabled
   function automatic logic reqIrq(input logic held, input logic irq_output_enable);
      return !held && irq_output_enable;
   endfunction

   // a data bit that is not a stuffed zero
   assign bitTick    = bitStrobe && (s_r.st != TX_IDLE);
   assign payloadBit = bitTick && !stuffNow && (s_r.st == TX_DATA);
   // a packet starts when data is loaded at the end of a flag and no abort is requested
   assign crcInit    = bitTick && !stuffNow && (s_r.cnt == LAST_BIT) && !s_r.abort_request &&
                       (s_r.st == TX_FLAG) && s_r.held;

   // ----------------------------------------------------------------
   // zero insertion and check sequence
   // ----------------------------------------------------------------
   // the run clears while idle, so a restart never stuffs a flag
   link_zero_stuffer u_stuff (
      .clk        (clk),
      .nrst       (nrst),
      .ce         (ce),
      .clr        (s_r.st == TX_IDLE),
      .adv        (bitTick),
      .countEn    ((s_r.st == TX_DATA) || (s_r.st == TX_FCS)),
      .sentBit    (s_r.sh[0]),
      .insertZero (stuffNow)
   );

   // the divider restarts when a packet's first byte loads
   fcs16_gen u_fcs (
      .clk     (clk),
      .nrst    (nrst),
      .ce      (ce),
      .init    (crcInit),
      .shiftEn (payloadBit),
      .dataBit (s_r.sh[0]),
      .crcNext (crcNext)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        setup;
      logic        wr;
      logic        wrData;
      logic [31:0] rd;
      s_nxt  = s_r;
      setup  = psel && !penable;
      wr     = psel && penable && s_r.pready && pwrite;
      wrData = wr && (paddr == ADDR_W'(ADDR_DATA));
      rd     = 32'h0000_0000;

      // ------------------------------------------------------------
      // register bus: read data and ready are prepared in setup
      // ------------------------------------------------------------
      unique case (1'b1)
         (paddr == ADDR_W'(ADDR_CFG)): begin
            rd[CFG_EN]   = s_r.en;
            rd[CFG_CRC]  = s_r.crcEn;
            rd[CFG_ABT]  = s_r.abort_request;
            rd[CFG_IRQ_OUTPUT_ENABLE] = s_r.irq_output_enable;
            rd[CFG_EOM]  = s_r.end_of_message_mark;
         end
         (paddr == ADDR_W'(ADDR_STAT)): begin
            rd[STAT_UDR]    = s_r.underrun_flag;
            rd[STAT_BYTREQ] = !s_r.held;
         end
         (paddr == ADDR_W'(ADDR_DATA)): begin
            rd[7:0] = s_r.dat;
         end
         (paddr == ADDR_W'(ADDR_OPT)): begin
            rd[OPT_ROUTE] = s_r.route;
         end
         default: begin
            rd = 32'h0000_0000;
         end
      endcase
      // zero wait states: the answer is registered in the setup cycle
      s_nxt.pready  = setup;
      s_nxt.pslverr = setup && !mapped(paddr);
      s_nxt.prdata  = setup ? rd : 32'h0000_0000;

      // ------------------------------------------------------------
      // register writes
      // ------------------------------------------------------------
      if (wr) begin
         unique case (1'b1)
            (paddr == ADDR_W'(ADDR_CFG)): begin
               s_nxt.en    = pwdata[CFG_EN];
               s_nxt.crcEn = pwdata[CFG_CRC];
               s_nxt.abort_request   = pwdata[CFG_ABT];
               s_nxt.irq_output_enable  = pwdata[CFG_IRQ_OUTPUT_ENABLE];
               s_nxt.end_of_message_mark   = pwdata[CFG_EOM];
            end
            (paddr == ADDR_W'(ADDR_STAT)): begin
               if (!pwdata[STAT_UDR]) begin
                  s_nxt.underrun_flag = 1'b0;
               end
            end
            (paddr == ADDR_W'(ADDR_DATA)): begin
               s_nxt.dat  = pwdata[7:0];
               // pending until the shifter takes it
               s_nxt.held = 1'b1;
            end
            (paddr == ADDR_W'(ADDR_OPT)): begin
               s_nxt.route = pwdata[OPT_ROUTE];
            end
            default: begin
               s_nxt.en = s_r.en;
            end
         endcase
      end

      // ------------------------------------------------------------
      // serial side, one line bit per strobe
      // ------------------------------------------------------------
      // disable cuts any unit at once and the line idles high
      if (!s_r.en) begin
         s_nxt.st  = TX_IDLE;
         s_nxt.cnt = 5'h00;
         if (bitStrobe) begin
            s_nxt.txBit = 1'b1;
         end
      end else if (s_r.st == TX_IDLE) begin
         // start on a whole flag so the far end never sees a cut unit
         s_nxt.st  = TX_FLAG;
         s_nxt.sh  = {8'h00, PAT_FLAG};
         s_nxt.cnt = BYTE_BITS;
         if (bitStrobe) begin
            s_nxt.txBit = 1'b1;
         end
      end else if (bitStrobe) begin
         if (stuffNow) begin
            s_nxt.txBit = 1'b0;
         end else begin
            s_nxt.txBit = s_r.sh[0];
            s_nxt.sh    = s_r.sh >> 1;
            s_nxt.cnt   = s_r.cnt - LAST_BIT;
            if (s_r.cnt == LAST_BIT) begin
               // aborts take the place of whatever would follow the unit
               if (s_r.abort_request) begin
                  s_nxt.st  = TX_ABORT;
                  s_nxt.sh  = {8'h00, PAT_ABORT};
                  s_nxt.cnt = BYTE_BITS;
               end else begin
                  unique case (s_r.st)
                     TX_FLAG, TX_DATA: begin
                        if (s_r.held) begin
                           s_nxt.st   = TX_DATA;
                           s_nxt.sh   = {8'h00, s_r.dat};
                           s_nxt.cnt  = BYTE_BITS;
                           // a write on the load edge stays pending for the next unit
                           s_nxt.held = wrData;
                           s_nxt.end_of_message_mark  = (s_r.st == TX_FLAG) ? 1'b0 : s_nxt.end_of_message_mark;
                        end else if (s_r.st == TX_FLAG) begin
                           s_nxt.sh  = {8'h00, PAT_FLAG};
                           s_nxt.cnt = BYTE_BITS;
                        end else if (s_r.end_of_message_mark) begin
                           s_nxt.end_of_message_mark = 1'b0;
                           if (s_r.crcEn) begin
                              s_nxt.st  = TX_FCS;
                              // complemented and reversed so bit 15 leaves first
                              s_nxt.sh  = {<<{~crcNext}};
                              s_nxt.cnt = FCS_BITS;
                           end else begin
                              s_nxt.st  = TX_FLAG;
                              s_nxt.sh  = {8'h00, PAT_FLAG};
                              s_nxt.cnt = BYTE_BITS;
                           end
                        end else begin
                           // assigned after the bus clear, so a same-cycle set wins
                           s_nxt.underrun_flag = 1'b1;
                           s_nxt.st  = TX_ABORT;
                           s_nxt.sh  = {8'h00, PAT_ABORT};
                           s_nxt.cnt = BYTE_BITS;
                        end
                     end
                     TX_FCS: begin
                        s_nxt.st  = TX_FLAG;
                        s_nxt.sh  = {8'h00, PAT_FLAG};
                        s_nxt.cnt = BYTE_BITS;
                     end
                     TX_ABORT: begin
                        s_nxt.st  = s_r.underrun_flag ? TX_UFLAG : TX_FLAG;
                        s_nxt.sh  = {8'h00, PAT_FLAG};
                        s_nxt.cnt = BYTE_BITS;
                     end
                     TX_UFLAG, TX_ONES: begin
                        // a clear that lands here resumes with flags first
                        s_nxt.st  = s_r.underrun_flag ? TX_ONES : TX_FLAG;
                        s_nxt.sh  = {8'h00, (s_r.underrun_flag ? PAT_ONES : PAT_FLAG)};
                        s_nxt.cnt = BYTE_BITS;
                     end
                     // not reached: disable and idle are handled above
                     TX_IDLE: begin
                        s_nxt.st = TX_IDLE;
                     end
                  endcase
               end
            end
         end
      end

      // ------------------------------------------------------------
      // interrupt outputs, registered so both pins are glitch free
      // ------------------------------------------------------------
      s_nxt.linkIrq  = reqIrq(s_nxt.held, s_nxt.irq_output_enable);
      s_nxt.hostIrqN = !(reqIrq(s_nxt.held, s_nxt.irq_output_enable) && s_nxt.route);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // the clock enable freezes everything, bus answers included
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= RESET_STATE;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata     = s_r.prdata;
   assign pready     = s_r.pready;
   assign pslverr    = s_r.pslverr;
   assign txBit      = s_r.txBit;
   assign linkIrqOut = s_r.linkIrq;
   assign hostIrqN   = s_r.hostIrqN;

endmodule
`default_nettype wire

// *** dv/link_hdlc_tx_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module link_hdlc_tx_chk
   import link_hdlc_tx_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              ce,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              bitStrobe,
   input wire logic              txBit,
   input wire logic              linkIrqOut,
   input wire logic              hostIrqN
);
   // ----
   // bus, line and interrupt relations
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic mapped;
   logic wrAcc;
   assign mapped = paddr inside {ADDR_CFG, ADDR_STAT, ADDR_DATA, ADDR_OPT};
   assign wrAcc = pready && pwrite && ce;
   setup_answer_a:
      assert property (psel && !penable && ce |=> pready) else $error("no answer");
   access_only_a:
      assert property (pready |-> psel && penable) else $error("pready outside access");
   unmapped_err_a:
      assert property (pready |-> pslverr == !mapped) else $error("bad slave error");
   idle_rdata_a:
      assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
   err_rdata_a:
      assert property (pslverr |-> prdata == 32'h0) else $error("data on error");
   line_hold_a:
      assert property (!(bitStrobe && ce) |=> $stable(txBit)) else $error("line moved");
   irq_drop_a:
      assert property (wrAcc && paddr == ADDR_DATA |-> ##1 !linkIrqOut)
      else $error("request stayed after data");
   irq_gate_a:
      assert property (wrAcc && paddr == ADDR_CFG && !pwdata[CFG_IRQ_OUTPUT_ENABLE] |-> ##2 !linkIrqOut)
      else $error("interrupt not gated");
   host_idle_a:
      assert property (!linkIrqOut [*2] |-> hostIrqN) else $error("host irq without link irq");
endmodule
bind link_hdlc_tx link_hdlc_tx_chk #(.ADDR_W(ADDR_W)) i_link_hdlc_tx_chk (
   .clk(clk), .nrst(nrst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .bitStrobe(bitStrobe), .txBit(txBit), .linkIrqOut(linkIrqOut), .hostIrqN(hostIrqN));
`default_nettype wire

// *** dv/link_framer_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module link_framer_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] period,
   input  wire logic       txBit,
   output logic            bitStrobe,
   output logic            frameDone,
   output logic [7:0]      frameLen,
   output logic [71:0]     frameBits,
   output logic [7:0]      abortCnt,
   output logic [7:0]      onesRun
);
   // ----
   // strobe source and flag-delimited receiver
   // ----
   logic [7:0] cnt;
   logic [7:0] nbits;
   logic [7:0] sh;
   // line sampled on the strobe edge: the bit from the previous strobe has stood a whole period
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {cnt, bitStrobe, frameDone, frameLen, abortCnt, onesRun, nbits, sh} <= '0;
         frameBits <= 72'h0;
      end else begin
         frameDone <= 1'b0;
         cnt <= (cnt + 8'h1 >= period) ? 8'h0 : cnt + 8'h1;
         bitStrobe <= (cnt == 8'h0);
         if (bitStrobe) begin
            sh <= {txBit, sh[7:1]};
            onesRun <= txBit ? onesRun + 8'(onesRun != 8'hff) : 8'h0;
            if (txBit && onesRun == 8'h6) begin
               abortCnt <= abortCnt + 8'h1;
               nbits <= 8'h0;
            end else if ({txBit, sh[7:1]} == 8'h7e) begin
               // short runs are flag or abort leftovers, not frames
               frameDone <= (nbits >= 8'h17);
               frameLen <= nbits - 8'h7;
               nbits <= 8'h0;
            end else if (!(onesRun == 8'h5 && !txBit) && nbits < 8'h48) begin
               frameBits[nbits] <= txBit;
               nbits <= nbits + 8'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/link_hdlc_tx_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module link_hdlc_tx_bench
   import link_hdlc_tx_pkg::*;
;
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic        bitStrobe, txBit, linkIrqOut, hostIrqN, frameDone;
   logic [7:0]  paddr, period, frameLen, abortCnt, onesRun, r, a0;
   logic [31:0] pwdata, prdata;
   logic [71:0] frameBits;
   logic [16:0] nt;
   logic [16:0] rq[$];
   logic [79:0] fq[$];
   int          fail_count, n_compared, cyc;

   link_hdlc_tx i_link_hdlc_tx (.clk(clk), .nrst(nrst), .ce(1'b1), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bitStrobe(bitStrobe), .txBit(txBit),
      .linkIrqOut(linkIrqOut), .hostIrqN(hostIrqN));
   link_framer_model i_link_framer_model (.clk(clk), .nrst(nrst), .period(period),
      .txBit(txBit), .bitStrobe(bitStrobe), .frameDone(frameDone), .frameLen(frameLen),
      .frameBits(frameBits), .abortCnt(abortCnt), .onesRun(onesRun));

   // ----
   // compares and bus tasks
   // ----
   task automatic fail(input string m);
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic chkRead(input logic [31:0] got, input logic [7:0] e, m);
      n_compared++;
      if (got[31:8] !== 24'h0 || (got[7:0] & m) !== (e & m)) fail("read data");
   endtask
   task automatic chkPin(input logic got, e);
      n_compared++;
      if (got !== e) fail("pin level");
   endtask
   task automatic chkFrame(input logic [79:0] e);
      logic [71:0] m;
      m = (72'h1 << e[79:72]) - 72'h1;
      n_compared++;
      if (frameLen !== e[79:72] || (frameBits & m) !== e[71:0]) fail("frame content");
   endtask
   // idle cycles after each transfer let registered interrupts settle before pins are read
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, e, m);
      rq.push_back({!(a inside {ADDR_CFG, ADDR_STAT, ADDR_DATA, ADDR_OPT}), m, e});
      apb(a, 1'b0, 8'h0);
   endtask
   task automatic waitReq;
      do rd(ADDR_STAT, 8'h0, 8'h0); while (r[STAT_BYTREQ] !== 1'b1);
   endtask
   task automatic sendFrame(input int n, input logic [7:0] cfg);
      logic [71:0] b;
      logic [15:0] c;
      logic [7:0]  d;
      int          k;
      b = 72'h0;
      c = CRC_INIT;
      k = 0;
      for (int i = 0; i < n; i++) begin
         d = (i == 0) ? 8'hff : 8'($urandom);
         for (int j = 0; j < 8; j++) begin
            b[k] = d[j];
            k++;
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[j]) ? CRC_POLY : 16'h0);
         end
         waitReq;
         wr(ADDR_DATA, d);
      end
      if (cfg[CFG_CRC]) for (int j = 15; j >= 0; j--) begin
         b[k] = ~c[j];
         k++;
      end
      fq.push_back({8'(k), b});
      wr(ADDR_CFG, cfg | 8'h10);
      while (fq.size() > 0) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ----
   // monitor, clock, timeout
   // ----
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
         nt = rq.pop_front();
         chkPin(pslverr, nt[16]);
         if (nt[15:8] != 8'h0) chkRead(prdata, nt[7:0], nt[15:8]);
      end
      if (frameDone === 1'b1) begin
         if (fq.size() > 0) chkFrame(fq.pop_front());
         else fail("unexpected frame");
      end
   end
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail("timeout");
         end_sim;
      end
   end

   // ----
   // main sequence
   // ----
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      period = 8'h0c;
      void'($urandom(5096));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(ADDR_CFG, 8'h00, 8'hff);
      rd(ADDR_STAT, 8'h02, 8'hff);
      rd(8'he0, 8'h00, 8'hff);
      wr(ADDR_OPT, 8'h01);
      wr(ADDR_CFG, 8'h08);
      chkPin(linkIrqOut, 1'b1);
      chkPin(hostIrqN, 1'b0);
      wr(ADDR_OPT, 8'h00);
      chkPin(hostIrqN, 1'b1);
      wr(ADDR_CFG, 8'h00);
      chkPin(linkIrqOut, 1'b0);
      rd(ADDR_STAT, 8'h02, 8'h02);
      wr(ADDR_CFG, 8'h0b);
      sendFrame(3, 8'h0b);
      rd(ADDR_CFG, 8'h0b, 8'hff);
      period <= 8'h1e;
      wr(ADDR_CFG, 8'h01);
      sendFrame(2, 8'h01);
      period <= 8'h0c;
      a0 = abortCnt;
      waitReq;
      wr(ADDR_DATA, 8'($urandom));
      repeat (720) @(posedge clk);
      rd(ADDR_STAT, 8'h03, 8'h03);
      chkPin(abortCnt != a0, 1'b1);
      chkPin(onesRun > 8'h8, 1'b1);
      wr(ADDR_STAT, 8'h01);
      rd(ADDR_STAT, 8'h03, 8'h03);
      wr(ADDR_STAT, 8'h00);
      rd(ADDR_STAT, 8'h02, 8'h03);
      a0 = abortCnt;
      wr(ADDR_CFG, 8'h05);
      repeat (480) @(posedge clk);
      chkPin(abortCnt - a0 > 8'h2, 1'b1);
      wr(ADDR_CFG, 8'h00);
      repeat (240) @(posedge clk);
      chkPin(txBit, 1'b1);
      chkPin(onesRun > 8'h10, 1'b1);
      end_sim;
   end
endmodule
`default_nettype wire
